//--- src/imp_pkg.sv
// Package for the interrupt mask, priority and external interrupt block.
// Assumes one 8-bit special-function register port from the processor core.
package imp_pkg;

  // Register addresses on the special-function register port
  localparam logic [7:0] ADDR_EN_PRI   = 8'hA8;
  localparam logic [7:0] ADDR_PR_PRI   = 8'hB8;
  localparam logic [7:0] ADDR_EN_EXT   = 8'hE6;
  localparam logic [7:0] ADDR_PR_EXT   = 8'hF6;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'hE4;
  localparam logic [7:0] ADDR_TMR_CTL  = 8'h88;

  // Reset values
  localparam logic [7:0] RST_EN_PRI    = 8'h00;
  localparam logic [7:0] RST_PR_PRI    = 8'h80;
  localparam logic [7:0] RST_EN_EXT    = 8'h00;
  localparam logic [7:0] RST_PR_EXT    = 8'h00;
  localparam logic [7:0] RST_PIN_CFG   = 8'h01;

  // Field layout
  localparam int unsigned GATE_BIT     = 7;
  localparam logic [7:0] PR_PRI_FIXED  = 8'h80;
  localparam logic [7:0] EXT_LIVE_MASK = 8'hB9;
  localparam int unsigned T2_BIT       = 5;
  localparam int unsigned T3_BIT       = 7;
  localparam int unsigned CMP_BIT      = 5;
  localparam int unsigned SENSE0_BIT   = 0;
  localparam int unsigned PEND0_BIT    = 1;
  localparam int unsigned SENSE1_BIT   = 2;
  localparam int unsigned PEND1_BIT    = 3;
  localparam int unsigned SEL0_LSB     = 0;
  localparam int unsigned POL0_BIT     = 3;
  localparam int unsigned SEL1_LSB     = 4;
  localparam int unsigned POL1_BIT     = 7;
  localparam int unsigned SEL_W        = 3;

  // Source indices in fixed arbitration order
  localparam int unsigned NUM_SRC      = 15;
  localparam logic [3:0] IDX_EXT0      = 4'h0;
  localparam logic [3:0] IDX_EXT1      = 4'h2;

  // Register write and read strobes from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] wrData;
  } imp_sfr_req_t;

  // Peripheral interrupt-pending flags
  typedef struct packed {
    logic timer0Flag;
    logic timer1Flag;
    logic uartFlag;
    logic timer2LowOverflow;
    logic timer2HighOverflow;
    logic spiFlag;
    logic smbusFlag;
    logic adcDoneFlag;
    logic counterArrayFlag;
    logic cmpRiseFlag;
    logic cmpFallFlag;
    logic timer3LowOverflow;
    logic timer3HighOverflow;
  } imp_src_flags_t;

endpackage : imp_pkg

//--- src/imp_ext_irq.sv
// One external interrupt front end: pin select, polarity, edge or level.
// Assumes port pins already synchronous to core_clk.
`timescale 1ns/1ps
module imp_ext_irq
  import imp_pkg::*;
#(
  parameter int unsigned PIN_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [PIN_W-1:0] portPins,
  input  wire logic [SEL_W-1:0] pinSel,
  input  wire logic             polarity,
  input  wire logic             senseEdge,
  input  wire logic             vectorAck,
  input  wire logic             swWr,
  input  wire logic             swVal,
  output logic                  pending
);

  // Pin count must be exactly what the select field can address
  if (PIN_W != (1 << SEL_W)) begin : gPinCheck
    $error("imp_ext_irq: PIN_W must match select width");
  end

  // State of this front end
  typedef struct packed {
    logic prevActive;
    logic pend;
  } imp_ext_state_t;

  imp_ext_state_t st_reg;
  imp_ext_state_t st_next;
  logic           active;   // Input active under polarity
  logic           edgeSeen; // Inactive to active transition

  // Read-only tap on the pin; the pin's other user is untouched
  assign active   = (portPins[pinSel] == polarity);
  assign edgeSeen = active && !st_reg.prevActive;
  assign pending  = st_reg.pend;

  // Next-state logic
  always_comb begin
    st_next            = st_reg;
    st_next.prevActive = active;
    if (!senseEdge) begin
      // Level mode: flag tracks input
      st_next.pend = active;
    end else if (edgeSeen) begin
      // Edge wins over any clear
      st_next.pend = 1'b1;
    end else if (vectorAck) begin
      // Core vectored to this routine
      st_next.pend = 1'b0;
    end else if (swWr) begin
      // Software set or clear
      st_next.pend = swVal;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  level_follow_a: assert property (@(posedge core_clk) disable iff (srst)
    !senseEdge |=> (pending == $past(active)))
    else $error("level flag does not follow input");

  sequence ackNoEdge;
    senseEdge && vectorAck && !edgeSeen;
  endsequence

  edge_ack_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    ackNoEdge |=> !pending)
    else $error("edge flag not cleared on vector");

  edge_set_a: assert property (@(posedge core_clk) disable iff (srst)
    (senseEdge && edgeSeen) |=> pending)
    else $error("edge not captured");

endmodule : imp_ext_irq

//--- src/imp_irq_ctrl.sv
// Interrupt enable, priority and external interrupt controller.
// Assumes a synchronous register port and vector handshake from the core.
//
// What this block does
// - Global gate off blocks every request
// - Primary mask bits pass sources bit 6..0
// - Timer 2 requests on either overflow flag
// - Primary priority bit 7 reads one
// - Primary priority bits mirror mask positions
// - Extended mask bits at 7,5,4,3,0
// - Extended reserved bits 6,2,1 read zero
// - Comparator requests on rise or fall
// - Timer 3 requests on either overflow flag
// - Extended priority bits at 7,5,4,3,0
// - Sense and polarity bits pick mode
// - External input taps pin without disturbing
// - Pending flags at control bits 1, 3
// - Edge flag clears on vectoring
// - Level flag follows active input
// - High preempts low, never preempted itself
// - High first, then fixed source order
// - Decode all pending requests every cycle
// - Three-bit field selects port 0 pin
`timescale 1ns/1ps
module imp_irq_ctrl
  import imp_pkg::*;
#(
  parameter int unsigned PIN_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire imp_sfr_req_t     sfrReq,
  output logic [7:0]            sfrRdData,
  input  wire logic [PIN_W-1:0] portPins,
  input  wire imp_src_flags_t   srcFlags,
  input  wire logic             vectorTake,
  input  wire logic             retiDone,
  output logic                  irqRequest,
  output logic [3:0]            irqIndex,
  output logic                  irqHigh,
  output logic [1:0]            inService
);

  // Pin count must be exactly what the select field can address
  if (PIN_W != (1 << SEL_W)) begin : gPinCheck
    $error("imp_irq_ctrl: PIN_W must match select width");
  end

  // Whole state of the controller
  typedef struct packed {
    logic [7:0] enPri;     // Primary mask and gate
    logic [7:0] prPri;     // Primary priority
    logic [7:0] enExt;     // Extended mask
    logic [7:0] prExt;     // Extended priority
    logic [7:0] pinCfg;    // Pin select and polarity
    logic [1:0] senseSel;  // Edge select per external input
    logic [7:0] rdData;    // Read answer
    logic       req;       // Request to core
    logic [3:0] idx;       // Chosen source
    logic       high;      // Chosen source is high priority
    logic       svcLow;    // Low routine running
    logic       svcHigh;   // High routine running
  } imp_state_t;

  imp_state_t           st_reg;
  imp_state_t           st_next;
  logic [1:0]           extPend;    // External pending flags
  logic [1:0]           extAck;     // Vector acknowledge per input
  logic                 tmrWr;      // Write to timer control
  logic [NUM_SRC-1:0]   srcEn;      // Per-source mask
  logic [NUM_SRC-1:0]   srcPri;     // Per-source level
  logic [NUM_SRC-1:0]   srcPend;    // Per-source pending
  logic [NUM_SRC-1:0]   hiCand;     // Enabled high requests
  logic [NUM_SRC-1:0]   loCand;     // Enabled low requests
  logic                 gate;       // Global gate
  logic [NUM_SRC-1:0]   liveSrc;    // Enabled and pending sources
  logic [NUM_SRC-1:0]   idxOneHot;  // Presented index as a one-hot vector
  logic [NUM_SRC-1:0]   idxBelow;   // Sources ahead of the presented one

  // Spread a primary/extended register pair over source indices
  function automatic logic [NUM_SRC-1:0] srcMap(input logic [7:0] pri, input logic [7:0] ext);
    logic [NUM_SRC-1:0] v;
    v      = '0;
    v[6:0] = pri[6:0];
    v[7]   = ext[0];
    v[10]  = ext[3];
    v[11]  = ext[4];
    v[12]  = ext[5];
    v[14]  = ext[7];
    return v;
  endfunction : srcMap

  // Lowest set index wins the fixed order
  function automatic logic [3:0] firstSet(input logic [NUM_SRC-1:0] v);
    logic [3:0] k;
    k = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        k = 4'(i);
      end
    end
    return k;
  endfunction : firstSet

  // External front ends, one per input
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gExt
      imp_ext_irq #(
        .PIN_W (PIN_W)
      ) uExt (
        .core_clk  (core_clk),
        .srst      (srst),
        .portPins  (portPins),
        .pinSel    (st_reg.pinCfg[g*4 +: SEL_W]),
        .polarity  (st_reg.pinCfg[g*4 + SEL_W]),
        .senseEdge (st_reg.senseSel[g]),
        .vectorAck (extAck[g]),
        .swWr      (tmrWr),
        .swVal     (sfrReq.wrData[g*2 + 1]),
        .pending   (extPend[g])
      );
    end
  endgenerate

  // Vector acknowledge steered to the chosen external input
  // A vector strobe with no live request clears nothing
  assign extAck[0] = vectorTake && st_reg.req && (st_reg.idx == IDX_EXT0);
  assign extAck[1] = vectorTake && st_reg.req && (st_reg.idx == IDX_EXT1);
  assign tmrWr     = sfrReq.wrEn && (sfrReq.addr == ADDR_TMR_CTL);

  // Source vectors decoded every cycle
  assign gate    = st_reg.enPri[GATE_BIT];
  assign srcEn   = srcMap(st_reg.enPri, st_reg.enExt);
  assign srcPri  = srcMap(st_reg.prPri, st_reg.prExt);
  always_comb begin
    srcPend     = '0;
    srcPend[0]  = extPend[0];
    srcPend[1]  = srcFlags.timer0Flag;
    srcPend[2]  = extPend[1];
    srcPend[3]  = srcFlags.timer1Flag;
    srcPend[4]  = srcFlags.uartFlag;
    srcPend[5]  = srcFlags.timer2LowOverflow | srcFlags.timer2HighOverflow;
    srcPend[6]  = srcFlags.spiFlag;
    srcPend[7]  = srcFlags.smbusFlag;
    srcPend[10] = srcFlags.adcDoneFlag;
    srcPend[11] = srcFlags.counterArrayFlag;
    srcPend[12] = srcFlags.cmpRiseFlag | srcFlags.cmpFallFlag;
    srcPend[14] = srcFlags.timer3LowOverflow | srcFlags.timer3HighOverflow;
  end
  assign hiCand = srcEn & srcPend & srcPri;
  assign loCand = srcEn & srcPend & ~srcPri;

  // Checker helpers: live sources and the presented index
  assign liveSrc   = srcEn & srcPend;
  assign idxOneHot = {{(NUM_SRC-1){1'b0}}, 1'b1} << irqIndex;
  assign idxBelow  = idxOneHot - {{(NUM_SRC-1){1'b0}}, 1'b1};

  // Outputs straight from state
  assign sfrRdData  = st_reg.rdData;
  assign irqRequest = st_reg.req;
  assign irqIndex   = st_reg.idx;
  assign irqHigh    = st_reg.high;
  assign inService  = {st_reg.svcHigh, st_reg.svcLow};

  // Next-state logic
  always_comb begin
    st_next = st_reg;

    // Register writes
    if (sfrReq.wrEn) begin
      unique case (sfrReq.addr)
        ADDR_EN_PRI:  st_next.enPri  = sfrReq.wrData;
        ADDR_PR_PRI:  st_next.prPri  = sfrReq.wrData | PR_PRI_FIXED;
        ADDR_EN_EXT:  st_next.enExt  = sfrReq.wrData & EXT_LIVE_MASK;
        ADDR_PR_EXT:  st_next.prExt  = sfrReq.wrData & EXT_LIVE_MASK;
        ADDR_PIN_CFG: st_next.pinCfg = sfrReq.wrData;
        ADDR_TMR_CTL: begin
          st_next.senseSel = {sfrReq.wrData[SENSE1_BIT], sfrReq.wrData[SENSE0_BIT]};
        end
        default: ;
      endcase
    end

    // Register reads, one cycle later; unmapped reads zero
    if (sfrReq.rdEn) begin
      unique case (sfrReq.addr)
        ADDR_EN_PRI:  st_next.rdData = st_reg.enPri;
        ADDR_PR_PRI:  st_next.rdData = st_reg.prPri | PR_PRI_FIXED;
        ADDR_EN_EXT:  st_next.rdData = st_reg.enExt & EXT_LIVE_MASK;
        ADDR_PR_EXT:  st_next.rdData = st_reg.prExt & EXT_LIVE_MASK;
        ADDR_PIN_CFG: st_next.rdData = st_reg.pinCfg;
        ADDR_TMR_CTL: begin
          st_next.rdData = '0;
          st_next.rdData[SENSE0_BIT] = st_reg.senseSel[0];
          st_next.rdData[PEND0_BIT]  = extPend[0];
          st_next.rdData[SENSE1_BIT] = st_reg.senseSel[1];
          st_next.rdData[PEND1_BIT]  = extPend[1];
        end
        default:      st_next.rdData = '0;
      endcase
    end

    // Service level tracking; a return closes the innermost routine
    if (retiDone) begin
      if (st_reg.svcHigh) begin
        st_next.svcHigh = 1'b0;
      end else begin
        st_next.svcLow = 1'b0;
      end
    end
    if (vectorTake && st_reg.req) begin
      if (st_reg.high) begin
        st_next.svcHigh = 1'b1;
      end else begin
        st_next.svcLow = 1'b1;
      end
    end

    // Arbitration each cycle
    st_next.req  = 1'b0;
    st_next.high = 1'b0;
    st_next.idx  = '0;
    if (!gate) begin
      // Gate closed: nothing is raised
      st_next.req = 1'b0;
    end else if (|hiCand && !st_next.svcHigh) begin
      // High may interrupt a low routine
      st_next.req  = 1'b1;
      st_next.high = 1'b1;
      st_next.idx  = firstSet(hiCand);
    end else if (|loCand && !st_next.svcHigh && !st_next.svcLow) begin
      // Low waits for any running routine
      st_next.req = 1'b1;
      st_next.idx = firstSet(loCand);
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg        <= '0;
      st_reg.enPri  <= RST_EN_PRI;
      st_reg.prPri  <= RST_PR_PRI;
      st_reg.enExt  <= RST_EN_EXT;
      st_reg.prExt  <= RST_PR_EXT;
      st_reg.pinCfg <= RST_PIN_CFG;
    end else begin
      st_reg <= st_next;
    end
  end

  // Helper: was any high candidate present last cycle
  logic anyHighQ;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      anyHighQ <= 1'b0;
    end else begin
      anyHighQ <= |hiCand;
    end
  end

  // Closed gate silences the request line
  gate_off_a: assert property (@(posedge core_clk) disable iff (srst)
    !gate |=> !irqRequest)
    else $error("request raised with gate closed");

  // Reads of the primary priority register
  sequence rdPri;
    sfrReq.rdEn && (sfrReq.addr == ADDR_PR_PRI);
  endsequence

  prio_bit7_a: assert property (@(posedge core_clk) disable iff (srst)
    rdPri |=> sfrRdData[7])
    else $error("priority bit 7 not read as one");

  // Reads of either extended register
  sequence rdExt;
    sfrReq.rdEn && ((sfrReq.addr == ADDR_EN_EXT) || (sfrReq.addr == ADDR_PR_EXT));
  endsequence

  resv_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    rdExt |=> ((sfrRdData & ~EXT_LIVE_MASK) == 8'h00))
    else $error("reserved bits not zero");

  // Either timer 2 overflow flag raises a request when idle
  timer2_pass_a: assert property (@(posedge core_clk) disable iff (srst)
    (gate && st_reg.enPri[T2_BIT] && srcPend[5] && !retiDone && !vectorTake
     && !st_reg.svcLow && !st_reg.svcHigh) |=> irqRequest)
    else $error("timer 2 request not passed");

  // Either comparator edge flag raises a request when idle
  cmp_pass_a: assert property (@(posedge core_clk) disable iff (srst)
    (gate && st_reg.enExt[CMP_BIT] && srcPend[12] && !vectorTake && !retiDone
     && !st_reg.svcLow && !st_reg.svcHigh) |=> irqRequest)
    else $error("comparator request not passed");

  // Either timer 3 overflow flag raises a request when idle
  timer3_pass_a: assert property (@(posedge core_clk) disable iff (srst)
    (gate && st_reg.enExt[T3_BIT] && srcPend[14] && !vectorTake && !retiDone
     && !st_reg.svcLow && !st_reg.svcHigh) |=> irqRequest)
    else $error("timer 3 request not passed");

  // A high request wins whenever one was waiting
  high_first_a: assert property (@(posedge core_clk) disable iff (srst)
    (irqRequest && $past(gate)) |-> (irqHigh == anyHighQ))
    else $error("low served ahead of high");

  // Nothing is raised while a high routine runs
  no_preempt_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_reg.svcHigh && !retiDone) |=> !irqRequest)
    else $error("high routine preempted");

  // Only an enabled, pending source may be presented
  enabled_only_a: assert property (@(posedge core_clk) disable iff (srst)
    irqRequest |-> (|($past(liveSrc) & idxOneHot)))
    else $error("request for disabled or idle source");

  // Level flag of the request matches its source's priority bit
  level_pick_a: assert property (@(posedge core_clk) disable iff (srst)
    irqRequest |-> (irqHigh == (|($past(srcPri) & idxOneHot))))
    else $error("request level differs from priority bit");

  // No lower-numbered source of the same level was waiting
  fixed_order_a: assert property (@(posedge core_clk) disable iff (srst)
    irqRequest |->
      (((irqHigh ? $past(hiCand) : $past(loCand)) & idxBelow) == '0))
    else $error("fixed source order broken");

  // Core takes a high request
  sequence takeHigh;
    vectorTake && irqRequest && irqHigh;
  endsequence

  // Core takes a low request
  sequence takeLow;
    vectorTake && irqRequest && !irqHigh;
  endsequence

  svc_high_a: assert property (@(posedge core_clk) disable iff (srst)
    takeHigh |=> inService[1])
    else $error("high routine not opened");

  svc_low_a: assert property (@(posedge core_clk) disable iff (srst)
    takeLow |=> inService[0])
    else $error("low routine not opened");

  // A running low routine holds off every low request
  low_wait_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_reg.svcLow && !retiDone && (hiCand == '0)) |=> !irqRequest)
    else $error("low request during low routine");

endmodule : imp_irq_ctrl

//--- tb/imp_core_model.sv
// Core-side model: turns bench commands into vector and return pulses.
// Assumes the bench drives commands by non-blocking assignment at falling edges.
`timescale 1ns/1ps
module imp_core_model (
  input  wire logic       core_clk,
  input  wire logic       takeCmd,
  input  wire logic       retiCmd,
  input  wire logic       irqRequest,
  input  wire logic [3:0] irqIndex,
  output logic            vectorTake,
  output logic            retiDone,
  output logic [3:0]      takenIdx
);
  // Quiet at time zero, then vector only onto a live request
  initial begin
    vectorTake = 1'b0;
    retiDone   = 1'b0;
    takenIdx   = 4'h0;
    forever begin
      @(negedge core_clk);
      vectorTake <= takeCmd && irqRequest && !vectorTake;
      retiDone   <= retiCmd && !retiDone;
      if (takeCmd && irqRequest) begin
        takenIdx <= irqIndex;
      end
    end
  end
endmodule : imp_core_model

//--- tb/test_interrupt_mask_priority_extint.sv
// Self-checking bench for the interrupt mask, priority and external interrupt block.
// Assumes the core model beside it; inputs change at falling edges.
`timescale 1ns/1ps
module test_interrupt_mask_priority_extint;
  import imp_pkg::*;
  logic           core_clk;
  logic           srst;
  imp_sfr_req_t   sfrReq;
  logic [7:0]     sfrRdData;
  logic [7:0]     portPins;
  imp_src_flags_t srcFlags;
  logic           vectorTake;
  logic           retiDone;
  logic           irqRequest;
  logic [3:0]     irqIndex;
  logic           irqHigh;
  logic [1:0]     inService;
  logic           takeCmd;
  logic           retiCmd;
  logic [3:0]     takenIdx;
  int             nFail;
  int             nCompared;
  // Source index per flag, flag struct taken from its top bit down
  logic [3:0] idxTab [13] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hC, 4'hE, 4'hE};

  imp_irq_ctrl #(.PIN_W(8)) imp_irq_ctrl_i (
    .core_clk(core_clk), .srst(srst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .portPins(portPins), .srcFlags(srcFlags), .vectorTake(vectorTake), .retiDone(retiDone),
    .irqRequest(irqRequest), .irqIndex(irqIndex), .irqHigh(irqHigh), .inService(inService));
  imp_core_model imp_core_model_i (
    .core_clk(core_clk), .takeCmd(takeCmd), .retiCmd(retiCmd), .irqRequest(irqRequest),
    .irqIndex(irqIndex), .vectorTake(vectorTake), .retiDone(retiDone), .takenIdx(takenIdx));

  // Clock at 40 MHz
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic giveVerdict;
    $display("compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : giveVerdict

  // One comparison, reported at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Register write, one edge wide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrReq <= '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
    @(negedge core_clk);
    sfrReq.wrEn <= 1'b0;
  endtask : wr

  // Register read, answer looked at one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    sfrReq <= '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
    @(negedge core_clk);
    sfrReq.rdEn <= 1'b0;
    chk(sfrRdData, exp);
  endtask : rd

  // Request outputs once settled; index only judged when a request is due
  task automatic req(input logic r, input logic h, input logic [3:0] i);
    cyc(3);
    chk(r ? {2'b00, irqRequest, irqHigh, irqIndex} : {7'h00, irqRequest}, {2'b00, r, h, i});
  endtask : req

  // Ask the core model to vector or to return
  task automatic vec;
    takeCmd <= 1'b1;
    cyc(1);
    takeCmd <= 1'b0;
    cyc(2);
  endtask : vec

  task automatic reti;
    retiCmd <= 1'b1;
    cyc(1);
    retiCmd <= 1'b0;
    cyc(2);
  endtask : reti

  task automatic t_reset;
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h80);
    rd(8'hE6, 8'h00);
    rd(8'hF6, 8'h00);
    rd(8'hE4, 8'h01);
    rd(8'h88, 8'h00);
    $display("reset values done");
  endtask : t_reset

  task automatic t_regs;
    wr(8'hA8, 8'hFF);
    wr(8'hB8, 8'h00);
    wr(8'hE6, 8'hB9); // (reserved bits written as zero)
    wr(8'hF6, 8'hB9);
    wr(8'h55, 8'hFF);
    rd(8'hA8, 8'hFF);
    rd(8'hB8, 8'h80);
    rd(8'hE6, 8'hB9);
    rd(8'hF6, 8'hB9);
    rd(8'h55, 8'h00);
    wr(8'hA8, 8'h00);
    wr(8'hF6, 8'h00);
    $display("register access done");
  endtask : t_regs

  task automatic t_sources;
    wr(8'hE6, 8'hB9);
    wr(8'hA8, 8'h7F);
    for (int k = 0; k < 13; k++) begin
      srcFlags <= 13'h1000 >> k;
      req(1'b0, 1'b0, 4'h0);
    end
    wr(8'hA8, 8'hFF);
    for (int k = 0; k < 13; k++) begin
      srcFlags <= 13'h1000 >> k;
      req(1'b1, 1'b0, idxTab[k]);
    end
    wr(8'hA8, 8'hFD);
    srcFlags <= 13'h1000;
    req(1'b0, 1'b0, 4'h0);
    wr(8'hA8, 8'hFF);
    $display("source masks done");
  endtask : t_sources

  task automatic t_prio;
    srcFlags <= 13'h1040;
    req(1'b1, 1'b0, 4'h1);
    wr(8'hF6, 8'h01);
    req(1'b1, 1'b1, 4'h7);
    wr(8'hB8, 8'h02);
    req(1'b1, 1'b1, 4'h1);
    wr(8'hB8, 8'h00);
    wr(8'hF6, 8'h00);
    $display("priority order done");
  endtask : t_prio

  task automatic t_preempt;
    srcFlags <= 13'h1000;
    req(1'b1, 1'b0, 4'h1);
    vec();
    chk({4'h0, takenIdx}, 8'h01);
    chk({6'h00, inService}, 8'h01);
    req(1'b0, 1'b0, 4'h0);
    wr(8'hB8, 8'h40);
    srcFlags <= 13'h1080;
    req(1'b1, 1'b1, 4'h6);
    vec();
    chk({6'h00, inService}, 8'h03);
    wr(8'hF6, 8'h01);
    srcFlags <= 13'h10C0;
    req(1'b0, 1'b0, 4'h0);
    reti();
    chk({6'h00, inService}, 8'h01);
    srcFlags <= 13'h0000;
    reti();
    chk({6'h00, inService}, 8'h00);
    wr(8'hB8, 8'h00);
    wr(8'hF6, 8'h00);
    $display("preemption done");
  endtask : t_preempt

  task automatic t_ext;
    // Edge mode, active high, every pin choice
    for (int p = 0; p < 8; p++) begin
      portPins <= 8'h00;
      wr(8'hE4, {5'b00001, p[2:0]});
      wr(8'h88, 8'h01);
      portPins <= ~(8'h01 << p);
      cyc(2);
      rd(8'h88, (p == 0) ? 8'h09 : 8'h01);
      portPins <= 8'hFF;
      cyc(2);
      rd(8'h88, 8'h03);
    end
    req(1'b1, 1'b0, 4'h0);
    vec();
    rd(8'h88, 8'h01);
    req(1'b0, 1'b0, 4'h0);
    // Level mode, ext1 on pin 2 active low; source holds then releases
    portPins <= 8'hFE;
    wr(8'hE4, 8'h28);
    wr(8'h88, 8'h00);
    reti();
    rd(8'h88, 8'h00);
    portPins <= 8'hFA;
    cyc(2);
    rd(8'h88, 8'h08);
    req(1'b1, 1'b0, 4'h2);
    portPins <= 8'hFE;
    cyc(2);
    rd(8'h88, 8'h00);
    req(1'b0, 1'b0, 4'h0);
    // Edge mode, ext1 active low on pin 2: the flag latches the falling edge
    wr(8'h88, 8'h04);
    portPins <= 8'hFA;
    cyc(2);
    portPins <= 8'hFE;
    rd(8'h88, 8'h0C);
    vec();
    chk({4'h0, takenIdx}, 8'h02);
    rd(8'h88, 8'h04);
    reti();
    chk({6'h00, inService}, 8'h00);
    $display("external inputs done");
  endtask : t_ext

  // Main sequence
  initial begin
    nFail = 0;
    nCompared = 0;
    srst = 1'b1;
    sfrReq = '0;
    srcFlags = '0;
    portPins = 8'hFF; // Pins idle high, as the port latches leave reset
    takeCmd = 1'b0;
    retiCmd = 1'b0;
    cyc(20);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_sources();
    t_prio();
    t_preempt();
    t_ext();
    giveVerdict();
  end

  // Watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    giveVerdict();
  end
endmodule : test_interrupt_mask_priority_extint
